// ### hw/led_sink_control_registers.v
// Functional notes
// - enable bit 4 drives sub sink two
// - enable bit 3 drives sub sink one
// - config 00 or 11 means shutdown, keep registers
// - config 01: active, fifth grouped, 25 mA
// - config 10: active, fifth aux, 80 mA
// - sub current code in bits 5..0
// - up to 1.5 mA step 0.1 mA
// - above 1.5 mA step 0.5 mA
// - main current code bits 5..0 sinks one-four
// - grouped fifth code from bits 7..2
// - aux dimming bits 3..2: 20/40/70/100 %
// - pump code 00 or 11 selects auto
// - pump code 01 forces 1x
// - pump code 10 forces 1.5x
// - open lamps never push auto pump to 1.5x while detection bit 6 is on
// - acknowledge every address, pointer and write byte once addressed; read bytes are acked by the master
`timescale 1ns/1ps
`include "led_sink_defines.vh"
module led_sink_control_registers #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary address value
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // two-wire bus pins, open drain data
    input wire busClk,
    input wire busDataIn,
    output reg busDataOut,
    output reg busDataOe,
    // analogue side status
    input wire lowInput,
    input wire lampOpen,
    // sink enables
    output reg deviceActive,
    output reg open_lamp_detect_on,
    output reg main_bank_on,
    output reg sub_sink_one_on,
    output reg sub_sink_two_on,
    output reg fifth_channel_on,
    output reg fifthAux,
    // current settings in microamps, aux dimming in percent
    output reg [15:0] subCurrentUa,
    output reg [15:0] mainCurrentUa,
    output reg [15:0] fifthCurrentUa,
    output reg [6:0] auxDimPct,
    // pump ratio: 1 means 1.5x
    output reg pumpRatio1p5
);
    // bus engine states
    // the ignore state parks a frame that is not ours until the next start or stop
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_REG = 3'd2;
    localparam ST_WDATA = 3'd3;
    localparam ST_RDATA = 3'd4;
    localparam ST_IGNORE = 3'd5;

    wire [1:0] lines; // synced {clk,data}
    reg sclPrev_q; // previous synced clock
    reg sdaPrev_q; // previous synced data
    reg [2:0] state_q; // bus state
    reg [3:0] bitCnt_q; // bit count, 8 = ack slot
    reg [7:0] shift_q; // shift register
    reg [7:0] ptr_q; // register pointer
    reg readDir_q; // current transfer is a read
    reg ackDrive_q; // holding data low for ack
    reg masterNack_q; // master refused read data

    // register file; all clear at reset, which decodes as shutdown
    // stored values are already masked, readback masks again for safety
    reg [7:0] enableReg_q;
    reg [7:0] subReg_q;
    reg [7:0] mainReg_q;
    reg [7:0] fifthReg_q;

    // pins come from outside, two flops each
    // clock and data share one synchroniser so their relative timing is kept
    line_sync #(.WIDTH(2)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn({busClk, busDataIn}),
        .syncOut(lines)
    );
    wire scl = lines[1];
    wire sda = lines[0];

    // edges seen on the sampled bus clock
    // reset to the idle high level so release of reset makes no false edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= scl;
            sdaPrev_q <= sda;
        end
    end
    wire sclRise = scl && !sclPrev_q;
    wire sclFall = !scl && sclPrev_q;
    // start and stop: data moves while clock high
    // both are checked ahead of the bit logic, so a frame can be cut anywhere
    wire startCond = scl && sclPrev_q && !sda && sdaPrev_q;
    wire stopCond = scl && sclPrev_q && sda && !sdaPrev_q;

    // readback; unused bits masked to zero
    // pointer values beyond the last register read as zero rather than alias
    reg [7:0] rdData;
    always @* begin
        case (ptr_q)
            `REG_ENABLE_OFS: rdData = enableReg_q & `ENABLE_MASK;
            `REG_SUB_OFS: rdData = subReg_q & `CODE_MASK;
            `REG_MAIN_OFS: rdData = mainReg_q & `CODE_MASK;
            `REG_FIFTH_OFS: rdData = fifthReg_q & `FIFTH_MASK;
            default: rdData = 8'h00; // unmapped reads zero
        endcase
    end

    // next shifter value, msb arrives first
    wire [7:0] rxByte = {shift_q[6:0], sda}; // byte complete on 8th rise

    // bus engine: sampling on rise, driving on fall
    // bitCnt_q 0..7 counts data bits, 8 marks the acknowledge slot;
    // the pin only ever changes one cycle after a seen fall (three after the clock pin falls), well inside
    // the low phase, so the data never moves while the bus clock is high
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'd0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            readDir_q <= 1'b0;
            ackDrive_q <= 1'b0;
            masterNack_q <= 1'b0;
            enableReg_q <= `ENABLE_RST;
            subReg_q <= `SUB_RST;
            mainReg_q <= `MAIN_RST;
            fifthReg_q <= `FIFTH_RST;
            busDataOut <= 1'b0;
            busDataOe <= 1'b0;
        end else if (startCond) begin
            // start or repeated start: fresh address byte
            // the start's own clock fall also passes the fall logic below,
            // so the count begins one below zero and wraps to 0 there;
            // otherwise the address byte would close after seven bits
            state_q <= ST_ADDR;
            bitCnt_q <= 4'd15;
            ackDrive_q <= 1'b0;
            busDataOe <= 1'b0;
        end else if (stopCond) begin
            state_q <= ST_IDLE;
            ackDrive_q <= 1'b0;
            busDataOe <= 1'b0;
        end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
            if (sclRise) begin
                if (bitCnt_q == 4'd8) begin
                    // ack slot: master answers on reads, unless we hold the line
                    if (!ackDrive_q && state_q == ST_RDATA) begin
                        masterNack_q <= sda;
                    end
                end else if (state_q != ST_RDATA) begin
                    // receive bit; during a read the shifter only moves on falls,
                    // sampling here too would skip every other outgoing bit
                    shift_q <= rxByte;
                end
            end else if (sclFall) begin
                if (bitCnt_q == 4'd7) begin
                    // byte just finished; decide ack
                    // a foreign address drops to ignore and never touches the pin
                    bitCnt_q <= 4'd8;
                    case (state_q)
                        ST_ADDR: begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                readDir_q <= shift_q[0];
                                ackDrive_q <= 1'b1;
                                busDataOe <= 1'b1;
                                busDataOut <= 1'b0;
                            end else begin
                                state_q <= ST_IGNORE; // not us, stay off bus
                            end
                        end
                        ST_REG: begin
                            ptr_q <= shift_q;
                            ackDrive_q <= 1'b1;
                            busDataOe <= 1'b1;
                            busDataOut <= 1'b0;
                        end
                        ST_WDATA: begin
                            // writes land only in used bits
                            case (ptr_q)
                                `REG_ENABLE_OFS: enableReg_q <= shift_q & `ENABLE_MASK;
                                `REG_SUB_OFS: subReg_q <= shift_q & `CODE_MASK;
                                `REG_MAIN_OFS: mainReg_q <= shift_q & `CODE_MASK;
                                `REG_FIFTH_OFS: fifthReg_q <= shift_q;
                                default: ; // unmapped write dropped
                            endcase
                            ptr_q <= ptr_q + 8'h01;
                            ackDrive_q <= 1'b1;
                            busDataOe <= 1'b1;
                            busDataOut <= 1'b0;
                        end
                        default: begin
                            // read byte sent; release for master ack
                            busDataOe <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                        end
                    endcase
                end else if (bitCnt_q == 4'd8) begin
                    // end of ack slot
                    // pointer already moved on; the next read byte is fetched here
                    bitCnt_q <= 4'd0;
                    ackDrive_q <= 1'b0;
                    busDataOe <= 1'b0;
                    case (state_q)
                        ST_ADDR: begin
                            if (readDir_q) begin
                                state_q <= ST_RDATA;
                                busDataOe <= !rdData[7];
                                busDataOut <= 1'b0;
                                shift_q <= rdData;
                            end else begin
                                state_q <= ST_REG;
                            end
                        end
                        ST_REG: state_q <= ST_WDATA;
                        ST_WDATA: state_q <= ST_WDATA;
                        ST_RDATA: begin
                            if (masterNack_q) begin
                                // master ended read; leave data high
                                state_q <= ST_IGNORE;
                            end else begin
                                busDataOe <= !rdData[7];
                                busDataOut <= 1'b0;
                                shift_q <= rdData;
                            end
                        end
                        default: state_q <= ST_IGNORE;
                    endcase
                end else begin
                    bitCnt_q <= bitCnt_q + 4'd1;
                    if (state_q == ST_RDATA) begin
                        // next read bit, open drain: drive only zeros
                        busDataOe <= !shift_q[6];
                        busDataOut <= 1'b0;
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // decoded configuration
    // shutdown only gates the outputs; the register file keeps its contents
    // so a host can leave shutdown without rewriting currents or policy
    wire [1:0] cfgCode = {enableReg_q[`CFG_HIGH_BIT], enableReg_q[`CFG_LOW_BIT]};
    wire activeNow = (cfgCode == `CFG_GROUPED) || (cfgCode == `CFG_AUX);
    wire auxNow = (cfgCode == `CFG_AUX);
    wire [1:0] pumpCode = fifthReg_q[1:0];

    // code to microamps: fine steps then coarse
    // code 15 is the top of the fine range, code 16 the first coarse step;
    // reported in microamps so both slopes stay exact integers
    function [15:0] code_to_ua;
        input [5:0] code;
        begin
            if (code <= `FINE_CODE_LAST) begin
                code_to_ua = {10'd0, code} * `FINE_STEP_UA;
            end else begin
                code_to_ua = `FINE_TOP_UA + {10'd0, code - `FINE_CODE_LAST} * `COARSE_STEP_UA;
            end
        end
    endfunction

    // aux dimming from two low code bits
    // upper code bits are ignored in aux mode; dimming is a fraction of 80 mA
    reg [6:0] auxPct;
    always @* begin
        case (fifthReg_q[3:2])
            2'b00: auxPct = `AUX_PCT_0;
            2'b01: auxPct = `AUX_PCT_1;
            2'b10: auxPct = `AUX_PCT_2;
            default: auxPct = `AUX_PCT_3;
        endcase
    end

    // pump decision; analogue flags sampled twice first
    // both flags come from comparators on their own timing, hence the flops;
    // the ratio itself is a request, the analogue stage does the switching
    reg [1:0] lowSync1_q; // first stage, only feeds second
    reg [1:0] lowSync2_q;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowSync1_q <= 2'b00;
            lowSync2_q <= 2'b00;
        end else begin
            lowSync1_q <= {lowInput, lampOpen};
            lowSync2_q <= lowSync1_q;
        end
    end
    // open lamp blocks the auto move to 1.5x when detection on
    // an open path would otherwise look like a low input and waste power
    wire autoUp = lowSync2_q[1] && !(enableReg_q[`EN_OLD_BIT] && lowSync2_q[0]);
    reg pumpNext;
    always @* begin
        case (pumpCode)
            `PUMP_FORCE_1X: pumpNext = 1'b0;
            `PUMP_FORCE_1P5X: pumpNext = 1'b1;
            default: pumpNext = autoUp;
        endcase
    end

    // registered outputs; shutdown gates enables, aux and pump off, current values still follow the codes
    // one cycle of latency after the register write is the price of
    // glitch-free outputs; every enable is qualified by the active state
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deviceActive <= 1'b0;
            open_lamp_detect_on <= 1'b0;
            main_bank_on <= 1'b0;
            sub_sink_one_on <= 1'b0;
            sub_sink_two_on <= 1'b0;
            fifth_channel_on <= 1'b0;
            fifthAux <= 1'b0;
            subCurrentUa <= 16'h0000;
            mainCurrentUa <= 16'h0000;
            fifthCurrentUa <= 16'h0000;
            auxDimPct <= 7'd0;
            pumpRatio1p5 <= 1'b0;
        end else begin
            deviceActive <= activeNow;
            open_lamp_detect_on <= activeNow && enableReg_q[`EN_OLD_BIT];
            main_bank_on <= activeNow && enableReg_q[`EN_MAIN_BIT];
            sub_sink_two_on <= activeNow && enableReg_q[`EN_SUB2_BIT];
            sub_sink_one_on <= activeNow && enableReg_q[`EN_SUB1_BIT];
            fifth_channel_on <= activeNow && enableReg_q[`EN_FIFTH_BIT];
            fifthAux <= auxNow;
            subCurrentUa <= code_to_ua(subReg_q[5:0]);
            mainCurrentUa <= code_to_ua(mainReg_q[5:0]);
            // grouped fifth uses bits 7..2; aux fixed at full scale 80 mA
            fifthCurrentUa <= auxNow ? 16'd0 : code_to_ua(fifthReg_q[7:2]);
            auxDimPct <= auxNow ? auxPct : 7'd0;
            pumpRatio1p5 <= activeNow && pumpNext;
        end
    end
endmodule // led_sink_control_registers

// ### hw/led_sink_defines.vh
`ifndef LED_SINK_DEFINES_VH
`define LED_SINK_DEFINES_VH
// register offsets
`define REG_ENABLE_OFS 8'h00
`define REG_SUB_OFS 8'h01
`define REG_MAIN_OFS 8'h02
`define REG_FIFTH_OFS 8'h03
// enable register fields
`define EN_OLD_BIT 6
`define EN_MAIN_BIT 5
`define EN_SUB2_BIT 4
`define EN_SUB1_BIT 3
`define EN_FIFTH_BIT 2
`define CFG_HIGH_BIT 1
`define CFG_LOW_BIT 0
// writable bit masks, unused bits read zero
`define ENABLE_MASK 8'h7F
`define CODE_MASK 8'h3F
`define FIFTH_MASK 8'hFF
// reset values, all clear gives shutdown
`define ENABLE_RST 8'h00
`define SUB_RST 8'h00
`define MAIN_RST 8'h00
`define FIFTH_RST 8'h00
// fifth channel configuration codes
`define CFG_GROUPED 2'b01
`define CFG_AUX 2'b10
// pump policy codes
`define PUMP_FORCE_1X 2'b01
`define PUMP_FORCE_1P5X 2'b10
// auxiliary dimming percentages
`define AUX_PCT_0 7'd20
`define AUX_PCT_1 7'd40
`define AUX_PCT_2 7'd70
`define AUX_PCT_3 7'd100
// sink current scale: codes 0..15 step 0.1 mA, then 0.5 mA
`define FINE_CODE_LAST 6'd15
`define FINE_STEP_UA 16'd100
`define COARSE_STEP_UA 16'd500
`define FINE_TOP_UA 16'd1500
// device address, arbitrary value
`define DEV_ADDR_DEFAULT 7'h2A
`endif

// ### hw/line_sync.v
`timescale 1ns/1ps
// two-stage synchroniser per bit
module line_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // async in, synced out
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_q; // first stage, read only by stage2
    reg [WIDTH-1:0] stage2_q; // settled value
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // idle high lines reset to one
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1_q[i] <= 1'b1;
                    stage2_q[i] <= 1'b1;
                end else begin
                    stage1_q[i] <= asyncIn[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate
    assign syncOut = stage2_q;
endmodule // line_sync

// ### dv/led_sink_props.sv
`timescale 1ns/1ps
module led_sink_props (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // bus data pin
    input logic busDataOut,
    input logic busDataOe,
    // sink controls
    input logic deviceActive,
    input logic open_lamp_detect_on,
    input logic main_bank_on,
    input logic sub_sink_one_on,
    input logic sub_sink_two_on,
    input logic fifth_channel_on,
    input logic fifthAux,
    input logic [15:0] subCurrentUa,
    input logic [15:0] mainCurrentUa,
    input logic [15:0] fifthCurrentUa,
    input logic [6:0] auxDimPct,
    input logic pumpRatio1p5
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // legal point on the two-slope current scale
    function automatic bit onScale(input logic [15:0] ua);
        return ua <= 16'h05DC ? ua % 16'h0064 == 0 : ua <= 16'h639C && (ua - 16'h05DC) % 16'h01F4 == 0;
    endfunction
    // any sink enable up, helper for shutdown check
    logic anyOn;
    assign anyOn = open_lamp_detect_on | main_bank_on | sub_sink_one_on | sub_sink_two_on | fifth_channel_on;
    a_shutdown_quiet: assert property (!deviceActive |-> !anyOn && !fifthAux)
        else $error("sink enabled in shutdown");
    a_shutdown_pump: assert property (!deviceActive |-> !pumpRatio1p5)
        else $error("pump boosted in shutdown");
    a_aux_needs_active: assert property (fifthAux |-> deviceActive)
        else $error("aux mode while inactive");
    a_aux_dim_legal: assert property (fifthAux |-> auxDimPct inside {7'h14, 7'h28, 7'h46, 7'h64} && fifthCurrentUa == 0)
        else $error("bad aux dimming");
    a_grouped_no_dim: assert property (!fifthAux |-> auxDimPct == 7'h00)
        else $error("dimming outside aux mode");
    a_sub_scale: assert property (onScale(subCurrentUa))
        else $error("sub current off scale");
    a_main_scale: assert property (onScale(mainCurrentUa))
        else $error("main current off scale");
    a_fifth_scale: assert property (onScale(fifthCurrentUa))
        else $error("fifth current off scale");
    a_ack_low: assert property (busDataOe |-> !busDataOut)
        else $error("ack drives data high");
    a_ack_hold: assert property ($rose(busDataOe) |-> busDataOe[*4])
        else $error("ack released too early");
    // main scenarios reached
    c_aux: cover property (fifthAux);
    c_pump: cover property ($rose(pumpRatio1p5));
    c_ack: cover property ($rose(busDataOe));
endmodule // led_sink_props
bind led_sink_control_registers led_sink_props led_sink_props_i (.core_clk, .rst_n, .busDataOut, .busDataOe,
    .deviceActive, .open_lamp_detect_on, .main_bank_on, .sub_sink_one_on, .sub_sink_two_on, .fifth_channel_on,
    .fifthAux, .subCurrentUa, .mainCurrentUa, .fifthCurrentUa, .auxDimPct, .pumpRatio1p5);

// ### dv/i2c_host.sv
`timescale 1ns/1ps
module i2c_host (
    // clock
    input logic core_clk,
    // wired data level
    input logic sdaLine,
    // host pins, idle high, clock still between frames
    output logic busClk,
    output logic sdaDrive
);
    initial begin
        busClk = 1'b1;
        sdaDrive = 1'b1;
    end
    // wait n core cycles
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one bit: low 5, high 3 cycles, 800 ns period
    task automatic bitIo(input logic b, output logic s);
        tick(2);
        sdaDrive <= b;
        tick(3);
        busClk <= 1'b1;
        tick(2);
        s = sdaLine;
        tick(1);
        busClk <= 1'b0;
    endtask
    // data falls while clock high
    task automatic start();
        tick(1);
        sdaDrive <= 1'b0;
        tick(3);
        busClk <= 1'b0;
    endtask
    // release data, raise clock, then start again
    task automatic restart();
        tick(2);
        sdaDrive <= 1'b1;
        tick(3);
        busClk <= 1'b1;
        tick(2);
        start();
    endtask
    // data rises while clock high
    task automatic stop();
        tick(2);
        sdaDrive <= 1'b0;
        tick(3);
        busClk <= 1'b1;
        tick(3);
        sdaDrive <= 1'b1;
        tick(4);
    endtask
    // msb first, line released in ack slot
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitIo(b[i], s);
        bitIo(1'b1, s);
        ack = !s;
    endtask
    // last byte answered with no ack
    task automatic recvByte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
        bitIo(last, s);
    endtask
endmodule // i2c_host

// ### dv/led_sink_control_registers_tb.sv
`timescale 1ns/1ps
module led_sink_control_registers_tb;
    localparam logic [6:0] ADDR = 7'h15; // arbitrary value
    // design pins
    logic core_clk, rst_n, busClk, sdaDrive, busDataIn, busDataOut, busDataOe, lowInput, lampOpen;
    logic deviceActive, open_lamp_detect_on, main_bank_on, sub_sink_one_on, sub_sink_two_on;
    logic fifth_channel_on, fifthAux, pumpRatio1p5;
    logic [15:0] subCurrentUa, mainCurrentUa, fifthCurrentUa;
    logic [6:0] auxDimPct;
    int failures = 0, comparisons = 0, i;
    logic [7:0] d;
    logic a0, a1, a2;
    logic [5:0] codes [5] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h3F};
    logic [6:0] pct [4] = '{7'h14, 7'h28, 7'h46, 7'h64};
    // pull-up on data, device only pulls low
    assign busDataIn = sdaDrive & ~(busDataOe & ~busDataOut);
    led_sink_control_registers #(.DEV_ADDR(ADDR)) led_sink_control_registers_i (.core_clk(core_clk),
        .rst_n(rst_n), .busClk(busClk), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
        .lowInput(lowInput), .lampOpen(lampOpen), .deviceActive(deviceActive),
        .open_lamp_detect_on(open_lamp_detect_on), .main_bank_on(main_bank_on), .sub_sink_one_on(sub_sink_one_on),
        .sub_sink_two_on(sub_sink_two_on), .fifth_channel_on(fifth_channel_on), .fifthAux(fifthAux),
        .subCurrentUa(subCurrentUa), .mainCurrentUa(mainCurrentUa), .fifthCurrentUa(fifthCurrentUa),
        .auxDimPct(auxDimPct), .pumpRatio1p5(pumpRatio1p5));
    i2c_host i2c_host_i (.core_clk(core_clk), .sdaLine(busDataIn), .busClk(busClk), .sdaDrive(sdaDrive));
    always #50 core_clk = ~core_clk;
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // expected microamps for a 64-step code
    function automatic logic [15:0] ua(input logic [5:0] c);
        return c <= 6'h0F ? c * 16'h0064 : 16'h05DC + (c - 6'h0F) * 16'h01F4;
    endfunction
    task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
        i2c_host_i.start();
        i2c_host_i.sendByte({ADDR, 1'b0}, a0);
        i2c_host_i.sendByte(ofs, a1);
        i2c_host_i.sendByte(v, a2);
        i2c_host_i.stop();
        chk({a0, a1, a2}, 16'h0007);
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
        i2c_host_i.start();
        i2c_host_i.sendByte({ADDR, 1'b0}, a0);
        i2c_host_i.sendByte(ofs, a1);
        i2c_host_i.restart();
        i2c_host_i.sendByte({ADDR, 1'b1}, a2);
        i2c_host_i.recvByte(v, 1'b1);
        i2c_host_i.stop();
        chk({a0, a1, a2}, 16'h0007);
    endtask
    // set pump policy and analogue status, then check ratio
    task automatic pump(input logic [7:0] en, input logic [1:0] m, input logic lo, input logic lamp, input logic e);
        lowInput <= lo;
        lampOpen <= lamp;
        wr(8'h00, en);
        wr(8'h03, {6'h00, m});
        repeat (6) @(posedge core_clk);
        chk(pumpRatio1p5, e);
    endtask
    task automatic finish_test();
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        finish_test();
    end
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        lowInput = 1'b0;
        lampOpen = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // all clear after reset
        for (i = 0; i < 4; i++) begin
            rd(8'(i), d);
            chk(d, '0);
        end
        chk(deviceActive, '0);
        // one enable bit at a time, stray bit 7 dropped
        for (i = 2; i < 7; i++) begin
            wr(8'h00, 8'h81 | (8'h01 << i));
            chk({open_lamp_detect_on, main_bank_on, sub_sink_two_on, sub_sink_one_on, fifth_channel_on},
                16'h0001 << (i - 2));
            chk({deviceActive, fifthAux}, 16'h0002);
            rd(8'h00, d);
            chk(d, 8'h01 | (8'h01 << i));
        end
        // current codes at both ends of each slope
        foreach (codes[k]) begin
            wr(8'h01, 8'hC0 | codes[k]);
            wr(8'h02, {2'b00, codes[k]});
            wr(8'h03, {codes[k], 2'b00});
            chk(subCurrentUa, ua(codes[k]));
            chk(mainCurrentUa, ua(codes[k]));
            chk(fifthCurrentUa, ua(codes[k]));
            chk(auxDimPct, '0);
            rd(8'h01, d);
            chk(d, codes[k]);
        end
        // auxiliary output, every dimming step, 1x forced
        lowInput <= 1'b1;
        wr(8'h00, 8'h06);
        chk({deviceActive, fifthAux, fifth_channel_on}, 16'h0007);
        for (i = 0; i < 4; i++) begin
            wr(8'h03, 8'hF1 | 8'(i << 2));
            chk(auxDimPct, pct[i]);
            chk(fifthCurrentUa, '0);
            chk(pumpRatio1p5, '0);
        end
        // pump policy codes and open lamp guard
        pump(8'h01, 2'b00, 1'b1, 1'b0, 1'b1);
        pump(8'h01, 2'b11, 1'b0, 1'b0, 1'b0);
        pump(8'h01, 2'b11, 1'b1, 1'b0, 1'b1);
        pump(8'h01, 2'b10, 1'b0, 1'b0, 1'b1);
        pump(8'h01, 2'b01, 1'b1, 1'b0, 1'b0);
        pump(8'h41, 2'b00, 1'b1, 1'b1, 1'b0);
        pump(8'h01, 2'b00, 1'b1, 1'b1, 1'b1);
        // both shutdown codes keep register contents
        for (i = 0; i < 2; i++) begin
            wr(8'h00, i ? 8'h7B : 8'h7C);
            chk({deviceActive, open_lamp_detect_on, main_bank_on, sub_sink_one_on, pumpRatio1p5}, '0);
            rd(8'h01, d);
            chk(d, 8'h3F);
        end
        // foreign address is not acknowledged
        i2c_host_i.start();
        i2c_host_i.sendByte({ADDR ^ 7'h01, 1'b0}, a0);
        i2c_host_i.stop();
        chk(a0, '0);
        rd(8'h07, d);
        chk(d, '0);
        finish_test();
    end
endmodule // led_sink_control_registers_tb
